// ### fcp_pkg.sv
// Constants for the flash configuration and protection register block
package fcp_pkg;
  // APB byte offsets
  localparam logic [7:0] ADDR_PROT = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  // Configuration register fields
  localparam int CFG_BE_IE = 7;
  localparam int CFG_CC_IE = 6;
  localparam int CFG_KEY = 5;
  // Protection register fields
  localparam int PROT_OPEN = 7;
  localparam int PROT_NV6 = 6;
  localparam int PROT_HDIS = 5;
  localparam int PROT_HS_LO = 3;
  localparam int PROT_LDIS = 2;
  localparam int PROT_LS_LO = 0;
  // Status register fields
  localparam int STAT_BE = 7;
  localparam int STAT_CC = 6;
  localparam int STAT_PROTECTION_VIOLATION_FLAG = 5;
  // Backdoor key field value that means enabled
  localparam logic [1:0] KEY_FIELD_ENABLED = 2'h2;
  // Values held under reset
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [7:0] PROT_RESET = 8'hff;
  // Flash location of the nonvolatile protection byte
  localparam logic [15:0] NV_PROT_ADDR = 16'hff0d;
  // Protection windows
  localparam logic [15:0] HIGH_START_2K = 16'hf800;
  localparam logic [15:0] HIGH_START_4K = 16'hf000;
  localparam logic [15:0] HIGH_START_8K = 16'he000;
  localparam logic [15:0] HIGH_START_16K = 16'hc000;
  localparam logic [15:0] LOW_START = 16'h4000;
  localparam logic [15:0] LOW_END_1K = 16'h43ff;
  localparam logic [15:0] LOW_END_2K = 16'h47ff;
  localparam logic [15:0] LOW_END_4K = 16'h4fff;
  localparam logic [15:0] LOW_END_8K = 16'h5fff;
endpackage

// ### fcp_regs.sv
// Flash configuration and protection registers with APB slave and window decoder
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module fcp_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] backdoor_key_enable_field,
  input wire logic [7:0] nv_prot_byte,
  input wire logic cmd_buffer_empty_flag,
  input wire logic cmd_complete_flag,
  input wire logic pe_req,
  input wire logic pe_mass,
  input wire logic [15:0] pe_addr,
  output logic pe_accept,
  output logic pe_refuse,
  output logic protection_violation_flag,
  output logic buffer_empty_irq,
  output logic cmd_complete_irq,
  output logic key_access_enable
);
  logic buffer_empty_irq_enable;
  logic cmd_complete_irq_enable;
  logic [7:0] flash_range_protection;
  logic prot_loaded;

  // APB decode; one wait state so read data can come from a flop
  wire logic access_wait = psel & penable & ~pready;
  wire logic access_done = psel & penable & pready;
  wire logic wr_fire = access_done & pwrite;
  wire logic hit_prot = paddr == fcp_pkg::ADDR_PROT;
  wire logic hit_cfg = paddr == fcp_pkg::ADDR_CFG;
  wire logic hit_stat = paddr == fcp_pkg::ADDR_STAT;
  wire logic mapped = hit_prot | hit_cfg | hit_stat;
  wire logic wr_cfg = wr_fire & hit_cfg;
  wire logic wr_prot = wr_fire & hit_prot & prot_loaded;
  wire logic wr_stat = wr_fire & hit_stat;

  // Only one of the four field codes opens the key path; the others all lock it
  wire logic key_enabled = backdoor_key_enable_field == fcp_pkg::KEY_FIELD_ENABLED;

  // Current protection fields
  wire logic cur_open = flash_range_protection[fcp_pkg::PROT_OPEN];
  wire logic cur_hdis = flash_range_protection[fcp_pkg::PROT_HDIS];
  wire logic cur_ldis = flash_range_protection[fcp_pkg::PROT_LDIS];
  wire logic [1:0] cur_hs = flash_range_protection[fcp_pkg::PROT_HS_LO +: 2];
  wire logic [1:0] cur_ls = flash_range_protection[fcp_pkg::PROT_LS_LO +: 2];

  // Requested protection fields
  wire logic req_open = pwdata[fcp_pkg::PROT_OPEN];
  wire logic req_hdis = pwdata[fcp_pkg::PROT_HDIS];
  wire logic req_ldis = pwdata[fcp_pkg::PROT_LDIS];
  wire logic [1:0] req_hs = pwdata[fcp_pkg::PROT_HS_LO +: 2];
  wire logic [1:0] req_ls = pwdata[fcp_pkg::PROT_LS_LO +: 2];

  // Transition check: with the polarity kept, a disable bit may only move towards
  // more protection; switching to open-low is allowed only over ranges that were
  // not protected before, since the new unprotected windows sit on them.
  wire logic open_ok = ~req_open | cur_open;
  wire logic h_keep_hi = cur_hdis | ~req_hdis;
  wire logic l_keep_hi = cur_ldis | ~req_ldis;
  wire logic h_keep_lo = ~cur_hdis | req_hdis;
  wire logic l_keep_lo = ~cur_ldis | req_ldis;
  wire logic h_swap_ok = cur_hdis | req_hdis;
  wire logic l_swap_ok = cur_ldis | req_ldis;
  wire logic stay_hi_ok = cur_open & req_open & h_keep_hi & l_keep_hi;
  wire logic stay_lo_ok = ~cur_open & ~req_open & h_keep_lo & l_keep_lo;
  wire logic swap_ok = cur_open & ~req_open & h_swap_ok & l_swap_ok;
  wire logic prot_write_ok = open_ok & (stay_hi_ok | stay_lo_ok | swap_ok);

  // Size fields frozen once their window is enabled
  wire logic [1:0] next_hs = cur_hdis ? req_hs : cur_hs;
  wire logic [1:0] next_ls = cur_ldis ? req_ls : cur_ls;

  logic [7:0] next_prot;
  always_comb begin
    next_prot = flash_range_protection;
    next_prot[fcp_pkg::PROT_OPEN] = req_open;
    next_prot[fcp_pkg::PROT_HDIS] = req_hdis;
    next_prot[fcp_pkg::PROT_LDIS] = req_ldis;
    next_prot[fcp_pkg::PROT_HS_LO +: 2] = next_hs;
    next_prot[fcp_pkg::PROT_LS_LO +: 2] = next_ls;
  end

  // Window decode against the live register contents
  // The map is 64K wide, so the high window always runs to the top address
  logic [15:0] high_start;
  logic [15:0] low_end;
  always_comb begin
    case (cur_hs)
      2'h0: high_start = fcp_pkg::HIGH_START_2K;
      2'h1: high_start = fcp_pkg::HIGH_START_4K;
      2'h2: high_start = fcp_pkg::HIGH_START_8K;
      default: high_start = fcp_pkg::HIGH_START_16K;
    endcase
    case (cur_ls)
      2'h0: low_end = fcp_pkg::LOW_END_1K;
      2'h1: low_end = fcp_pkg::LOW_END_2K;
      2'h2: low_end = fcp_pkg::LOW_END_4K;
      default: low_end = fcp_pkg::LOW_END_8K;
    endcase
  end

  wire logic in_high = ~cur_hdis & (pe_addr >= high_start);
  wire logic in_low = ~cur_ldis & (pe_addr >= fcp_pkg::LOW_START) & (pe_addr <= low_end);
  wire logic in_window = in_high | in_low;
  wire logic addr_protected = cur_open ? in_window : ~in_window;
  wire logic mass_ok = cur_open & cur_hdis & cur_ldis;
  wire logic pe_blocked = pe_mass ? ~mass_ok : addr_protected;
  // Attempts in the load cycle are dropped because the windows are not valid yet
  wire logic pe_valid = pe_req & prot_loaded;

  wire logic protection_violation_flag_set = pe_valid & pe_blocked;
  wire logic protection_violation_flag_clr = wr_stat & pwdata[fcp_pkg::STAT_PROTECTION_VIOLATION_FLAG];

  // Read mux
  // Unmapped addresses and the unused bits read as zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_prot) begin
      rd_byte = flash_range_protection;
    end else if (hit_cfg) begin
      rd_byte[fcp_pkg::CFG_BE_IE] = buffer_empty_irq_enable;
      rd_byte[fcp_pkg::CFG_CC_IE] = cmd_complete_irq_enable;
      rd_byte[fcp_pkg::CFG_KEY] = key_access_enable;
    end else if (hit_stat) begin
      rd_byte[fcp_pkg::STAT_BE] = cmd_buffer_empty_flag;
      rd_byte[fcp_pkg::STAT_CC] = cmd_complete_flag;
      rd_byte[fcp_pkg::STAT_PROTECTION_VIOLATION_FLAG] = protection_violation_flag;
    end
  end

  // APB answer: pready rises in the second access cycle and drops after one
  // cycle, so a master that holds its request sees a new completion every second cycle.
  wire logic next_pready = access_wait;
  wire logic next_pslverr = access_wait & ~mapped;
  wire logic rd_capture = access_wait & ~pwrite;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  // Read data only moves on a read, so it stays valid until the next read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd_capture) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // Configuration register; the key bit has its own write strobe because the
  // security field may block it while the enables in the same byte still land.
  wire logic wr_key = wr_cfg & key_enabled;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      buffer_empty_irq_enable <= fcp_pkg::CFG_RESET[2];
    end else if (wr_cfg) begin
      buffer_empty_irq_enable <= pwdata[fcp_pkg::CFG_BE_IE];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_complete_irq_enable <= fcp_pkg::CFG_RESET[1];
    end else if (wr_cfg) begin
      cmd_complete_irq_enable <= pwdata[fcp_pkg::CFG_CC_IE];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      key_access_enable <= fcp_pkg::CFG_RESET[0];
    end else if (wr_key) begin
      key_access_enable <= pwdata[fcp_pkg::CFG_KEY];
    end
  end

  // Protection register: constant under reset, nonvolatile byte caught on the
  // first edge after release, before any bus write can land.
  wire logic prot_update = wr_prot & prot_write_ok;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_range_protection <= fcp_pkg::PROT_RESET;
    end else if (!prot_loaded) begin
      flash_range_protection <= nv_prot_byte;
    end else if (prot_update) begin
      flash_range_protection <= next_prot;
    end
  end

  // Load marker: low through reset and on the first edge after it. Protection writes
  // and erase attempts are held off until the register holds the nonvolatile
  // byte, so nothing can race the load.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prot_loaded <= 1'b0;
    end else begin
      prot_loaded <= 1'b1;
    end
  end

  // Violation flag: set wins over a write-one clear in the same cycle
  // Writing zero to the flag's status bit leaves it alone
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      protection_violation_flag <= 1'b0;
    end else if (protection_violation_flag_set) begin
      protection_violation_flag <= 1'b1;
    end else if (protection_violation_flag_clr) begin
      protection_violation_flag <= 1'b0;
    end
  end

  // Program/erase verdict: one-cycle pulses, one cycle after the attempt
  wire logic next_pe_accept = pe_valid & ~pe_blocked;
  wire logic next_pe_refuse = pe_valid & pe_blocked;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pe_accept <= 1'b0;
    end else begin
      pe_accept <= next_pe_accept;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pe_refuse <= 1'b0;
    end else begin
      pe_refuse <= next_pe_refuse;
    end
  end

  // Interrupt requests follow enable AND flag with one flop of delay; the flags
  // are levels, so a request stays up exactly as long as both inputs do.
  wire logic next_be_irq = buffer_empty_irq_enable & cmd_buffer_empty_flag;
  wire logic next_cc_irq = cmd_complete_irq_enable & cmd_complete_flag;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      buffer_empty_irq <= 1'b0;
    end else begin
      buffer_empty_irq <= next_be_irq;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_complete_irq <= 1'b0;
    end else begin
      cmd_complete_irq <= next_cc_irq;
    end
  end

  // key_access_enable is exported so the array path treats writes as key words
  // and returns invalid read data that path lives outside this block.
endmodule

// ### fcp_regs_checker.sv
// Port assertions for the flash configuration and protection registers
`timescale 1ns/1ns
module fcp_regs_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] backdoor_key_enable_field,
  input wire logic cmd_buffer_empty_flag,
  input wire logic cmd_complete_flag,
  input wire logic pe_req,
  input wire logic pe_accept,
  input wire logic pe_refuse,
  input wire logic protection_violation_flag,
  input wire logic buffer_empty_irq,
  input wire logic cmd_complete_irq,
  input wire logic key_access_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic mapped = paddr inside {fcp_pkg::ADDR_PROT, fcp_pkg::ADDR_CFG, fcp_pkg::ADDR_STAT};
  a_be_irq_off: assert property (!cmd_buffer_empty_flag |=> !buffer_empty_irq)
    else $error("buffer empty irq without flag");
  a_cc_irq_off: assert property (!cmd_complete_flag |=> !cmd_complete_irq)
    else $error("complete irq without flag");
  a_pe_answer: assert property (pe_req && $past(rst_b) |=> pe_accept != pe_refuse)
    else $error("attempt not answered once");
  a_pe_quiet: assert property (!pe_req |=> !pe_accept && !pe_refuse)
    else $error("answer without attempt");
  a_refuse_flag: assert property (pe_refuse |-> protection_violation_flag)
    else $error("refusal without violation flag");
  a_apb_answer: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("apb answer timing");
  a_apb_error: assert property (pready |-> pslverr == !mapped)
    else $error("apb error response wrong");
  a_key_gate: assert property ($changed(key_access_enable) |->
    $past(backdoor_key_enable_field) == fcp_pkg::KEY_FIELD_ENABLED)
    else $error("key access changed while key disabled");
  c_refuse: cover property (pe_refuse);
  c_key: cover property ($rose(key_access_enable));
  c_irq: cover property (buffer_empty_irq && cmd_complete_irq);
endmodule

// ### fcp_regs_test.sv
// Self-checking bench for the flash configuration and protection registers
`timescale 1ns/1ns
module fcp_regs_test;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pe_req = 0, pe_mass = 0;
  logic be = 0, cc = 0, sl;
  logic [7:0] paddr = 0, nv = 8'hff, p;
  logic [31:0] pwdata = 0, prdata, r, x;
  logic [1:0] kf = 0;
  logic [15:0] pe_addr = 0;
  logic pready, pslverr, acc, ref_o, viol, be_irq, cc_irq, key;
  int err_count = 0, checked = 0, cyc = 0;
  always #10 clk = ~clk;
  fcp_regs u_fcp_regs (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .backdoor_key_enable_field(kf), .nv_prot_byte(nv),
    .cmd_buffer_empty_flag(be), .cmd_complete_flag(cc), .pe_req(pe_req), .pe_mass(pe_mass),
    .pe_addr(pe_addr), .pe_accept(acc), .pe_refuse(ref_o), .protection_violation_flag(viol),
    .buffer_empty_irq(be_irq), .cmd_complete_irq(cc_irq), .key_access_enable(key));
  task automatic results;
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      results;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // Every transfer starts after an edge, so back-to-back calls never clash
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    sl = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic refused(input logic [7:0] q, input logic [15:0] a, input logic m);
    logic hi, lo;
    hi = !q[5] && a >= (16'hf800 << q[4:3]);
    lo = !q[2] && a >= 16'h4000 && (a - 16'h4000) < (16'h0400 << q[1:0]);
    if (m) return !(q[7] && q[5] && q[2]);
    return q[7] ? (hi || lo) : !(hi || lo);
  endfunction
  task automatic pe(input logic [15:0] a, input logic m);
    @(posedge clk);
    pe_req <= 1;
    pe_addr <= a;
    pe_mass <= m;
    @(posedge clk) pe_req <= 0;
    @(posedge clk);
    chk(ref_o, refused(p, a, m));
    chk(acc, !refused(p, a, m));
  endtask
  task automatic pe_all;
    logic [15:0] c[6] = '{16'hf000, 16'hefff, 16'hc000, 16'h4fff, 16'h5000, 16'h4000};
    foreach (c[i]) pe(c[i], 0);
    repeat (12) pe(16'($urandom), 0);
    pe(16'h0, 1);
    pe(fcp_pkg::NV_PROT_ADDR, 0);
  endtask
  task automatic rst(input logic [7:0] v);
    rst_b <= 0;
    nv <= v;
    repeat (10) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(posedge clk);
    apb(0, fcp_pkg::ADDR_PROT, 0);
    chk(r, {24'h0, v});
    p = v;
  endtask
  initial begin
    logic [7:0] w[6] = '{8'hee, 8'hce, 8'hd6, 8'hee, 8'hca, 8'hcb};
    logic [7:0] e[6] = '{8'hee, 8'hce, 8'hce, 8'hce, 8'hca, 8'hca};
    void'($urandom(32'h284f));
    rst(8'hff);
    for (int k = 0; k < 4; k++) begin
      kf <= 2'(k);
      apb(1, fcp_pkg::ADDR_CFG, 8'hff);
      apb(0, fcp_pkg::ADDR_CFG, 0);
      chk(r, {24'h0, 2'b11, k == 2, 5'h0});
      chk(key, k == 2);
      kf <= 2'h2;
      apb(1, fcp_pkg::ADDR_CFG, 0);
    end
    kf <= 0;
    // First pass is the corner with both enables and both flags set
    for (int j = 0; j < 9; j++) begin
      x = (j == 0) ? 32'h0000_03c0 : $urandom;
      apb(1, fcp_pkg::ADDR_CFG, x[7:0]);
      be <= x[9];
      cc <= x[8];
      repeat (3) @(posedge clk);
      chk(be_irq, x[7] & x[9]);
      chk(cc_irq, x[6] & x[8]);
    end
    apb(0, 8'h10, 0);
    chk(sl, 1);
    chk(r, 0);
    pe_all;
    foreach (w[i]) begin
      apb(1, fcp_pkg::ADDR_PROT, w[i]);
      apb(0, fcp_pkg::ADDR_PROT, 0);
      chk(r, {24'h0, e[i]});
    end
    p = 8'hca;
    pe_all;
    chk(viol, 1);
    apb(1, fcp_pkg::ADDR_STAT, 8'h20);
    apb(0, fcp_pkg::ADDR_STAT, 0);
    chk(r[5], 0);
    rst(8'h4e);
    apb(1, fcp_pkg::ADDR_PROT, 8'hce);
    apb(0, fcp_pkg::ADDR_PROT, 0);
    chk(r, 32'h4e);
    pe_all;
    results;
  end
endmodule
bind fcp_regs fcp_regs_checker u_fcp_regs_checker (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .backdoor_key_enable_field(backdoor_key_enable_field),
  .cmd_buffer_empty_flag(cmd_buffer_empty_flag), .cmd_complete_flag(cmd_complete_flag),
  .pe_req(pe_req), .pe_accept(pe_accept), .pe_refuse(pe_refuse),
  .protection_violation_flag(protection_violation_flag), .buffer_empty_irq(buffer_empty_irq),
  .cmd_complete_irq(cmd_complete_irq), .key_access_enable(key_access_enable));
